// >>> hdl/itfc_pkg.sv
// Purpose: constants and types shared by the instruction trace filter control block
// Assumes: byte offsets on the debug register port, 32-bit words
// Notes: all register reset values are zero
package itfc_pkg;

  // register byte offsets
  localparam logic [11:0] ITFC_OFF_TS_CTRL = 12'h030;
  localparam logic [11:0] ITFC_OFF_SRC_ID = 12'h040;
  localparam logic [11:0] ITFC_OFF_VI_MAIN = 12'h080;
  localparam logic [11:0] ITFC_OFF_VI_RANGE = 12'h084;
  localparam logic [11:0] ITFC_OFF_VI_SS = 12'h088;
  localparam logic [11:0] ITFC_OFF_GM_VAL_LO = 12'h640;
  localparam logic [11:0] ITFC_OFF_GM_VAL_HI = 12'h644;
  localparam logic [11:0] ITFC_OFF_GM_MASK = 12'h688;

  // writable bits per register; everything else reads zero, except main control bit 9, which shows the start/stop state
  localparam logic [31:0] ITFC_WM_TS_CTRL = 32'h0000008e;
  localparam logic [31:0] ITFC_WM_SRC_ID = 32'h0000007f;
  localparam logic [31:0] ITFC_WM_VI_MAIN = 32'h007b0c8f;
  localparam logic [31:0] ITFC_WM_VI_RANGE = 32'h000f000f;
  localparam logic [31:0] ITFC_WM_VI_SS = 32'h00ff00ff;
  localparam logic [31:0] ITFC_WM_GM_MASK = 32'h0000000f;

  // reset values
  localparam logic [31:0] ITFC_RST_REG = 32'h00000000;
  localparam logic [31:0] ITFC_RST_GM_VAL = 32'h00000000;

  // field positions
  localparam int ITFC_TS_TYPE_BIT = 7;
  localparam int ITFC_TS_SEL_LSB = 1;
  localparam int ITFC_VI_TYPE_BIT = 7;
  localparam int ITFC_VI_SEL_LSB = 0;
  localparam int ITFC_VI_SS_BIT = 9;
  localparam int ITFC_VI_RST_BIT = 10;
  localparam int ITFC_VI_ERR_BIT = 11;
  localparam int ITFC_VI_SDIS_LSB = 16;
  localparam int ITFC_VI_NSDIS_LSB = 20;
  localparam int ITFC_INCL_LSB = 0;
  localparam int ITFC_EXCL_LSB = 16;
  localparam int ITFC_START_LSB = 0;
  localparam int ITFC_STOP_LSB = 16;
  localparam int ITFC_SRC_ID_W = 7;

  // implemented comparators
  localparam int ITFC_NUM_ARC = 4;
  localparam int ITFC_NUM_SAC = 8;

  // start/stop logic state, one-hot
  typedef enum logic [1:0]
  {
    ITFC_STOPPED = 2'b01,
    ITFC_STARTED = 2'b10
  } itfc_ss_e;

endpackage : itfc_pkg

// >>> hdl/itfc_gm_if.sv
// Purpose: carries the guest machine tag comparison between control and comparator
// Assumes: single clock domain
// Notes: match is registered inside the comparator
`timescale 1ns/1ps
interface itfc_gm_if;
  logic [31:0] cmpValue;
  logic [3:0] ignoreMask;
  logic [31:0] curTag;
  logic match;
  modport ctrl (output cmpValue, output ignoreMask, output curTag, input match);
  modport cmp (input cmpValue, input ignoreMask, input curTag, output match);
endinterface : itfc_gm_if

// >>> hdl/itfc_guest_cmp.sv
// Purpose: byte-masked guest machine tag comparator
// Assumes: tag and compare value change synchronously to clk
// Notes: match appears one cycle after its inputs
`timescale 1ns/1ps
module itfc_guest_cmp
  import itfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  itfc_gm_if.cmp gm
);

  logic [3:0] byteOk;

  // a masked byte always agrees; an unmasked byte must be equal
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_byte
      assign byteOk[gi] = gm.ignoreMask[gi] | (gm.cmpValue[gi*8 +: 8] == gm.curTag[gi*8 +: 8]);
    end
  endgenerate

  // registered so the top output comes from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gm.match <= 1'b0;
    else
      gm.match <= &byteOk;
  end

  chk_full_mask_match: assert property (@(posedge clk) disable iff (rst)
    (gm.ignoreMask == 4'hf) |=> gm.match)
    else $error("fully masked compare did not match");

endmodule : itfc_guest_cmp

// >>> hdl/itfc_filter_ctrl.sv
// Purpose: register file and instruction view filter of the instruction trace unit
// Assumes: comparator and resource results arrive as synchronous levels
// Notes: register port answers every access with one ack pulse one cycle later
`timescale 1ns/1ps

// What this block does
// - seven-bit source tag drives trace ID
// - timestamp request when selected event fires
// - timestamp event: type bit plus selector
// - non-secure per-level trace disable, bit23 zero
// - secure per-level trace disable, bit18 zero
// - system error traced if forced or preceded
// - reset exception traced if forced or preceded
// - start/stop state readable in bit 9
// - view event: single resource or pair
// - per-range include and exclude selects
// - empty include set includes everything
// - per-comparator start and stop selects
// - mask bit per byte ignores it
// - 64-bit compare value, upper half zero
// - registers decoded at fixed offsets
module itfc_filter_ctrl
  import itfc_pkg::*;
#(
  parameter int NUM_ARC = ITFC_NUM_ARC,
  parameter int NUM_SAC = ITFC_NUM_SAC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regAck,
  input wire logic [15:0] resSingle,
  input wire logic [7:0] resPair,
  input wire logic instValid,
  input wire logic instSecure,
  input wire logic [1:0] instLevel,
  input wire logic excReset,
  input wire logic excSysError,
  input wire logic [NUM_ARC-1:0] rangeMatch,
  input wire logic [NUM_SAC-1:0] singleAddrMatch,
  input wire logic [31:0] curGuestTag,
  output logic traceValid,
  output logic [ITFC_SRC_ID_W-1:0] traceIdOut,
  output logic timestampReq,
  output logic guestTagMatch
);

  // register storage
  logic [31:0] tsCtrl;
  logic [31:0] srcId;
  logic [31:0] viMain;
  logic [31:0] viRange;
  logic [31:0] viSs;
  logic [31:0] gmValue;
  logic [31:0] gmMask;
  itfc_ss_e ssState;
  itfc_ss_e next_ssState;
  logic tsEventD;
  logic prevTraced;

  // address decode
  wire wrEn = regSel & regWrite;
  wire rdEn = regSel & ~regWrite;
  wire hitTs = (regAddr == ITFC_OFF_TS_CTRL);
  wire hitId = (regAddr == ITFC_OFF_SRC_ID);
  wire hitMain = (regAddr == ITFC_OFF_VI_MAIN);
  wire hitRange = (regAddr == ITFC_OFF_VI_RANGE);
  wire hitSs = (regAddr == ITFC_OFF_VI_SS);
  wire hitGmLo = (regAddr == ITFC_OFF_GM_VAL_LO);
  wire hitGmHi = (regAddr == ITFC_OFF_GM_VAL_HI);
  wire hitGmMask = (regAddr == ITFC_OFF_GM_MASK);

  // named fields
  wire started = (ssState == ITFC_STARTED);
  wire tsType = tsCtrl[ITFC_TS_TYPE_BIT];
  wire [2:0] tsSel = tsCtrl[ITFC_TS_SEL_LSB +: 3];
  wire viType = viMain[ITFC_VI_TYPE_BIT];
  wire [3:0] viSel = viMain[ITFC_VI_SEL_LSB +: 4];
  wire [3:0] nsDisable = viMain[ITFC_VI_NSDIS_LSB +: 4];
  wire [3:0] sDisable = viMain[ITFC_VI_SDIS_LSB +: 4];
  wire forceErr = viMain[ITFC_VI_ERR_BIT];
  wire forceRst = viMain[ITFC_VI_RST_BIT];
  wire [NUM_ARC-1:0] inclSel = viRange[ITFC_INCL_LSB +: NUM_ARC];
  wire [NUM_ARC-1:0] exclSel = viRange[ITFC_EXCL_LSB +: NUM_ARC];
  wire [NUM_SAC-1:0] startSel = viSs[ITFC_START_LSB +: NUM_SAC];
  wire [NUM_SAC-1:0] stopSel = viSs[ITFC_STOP_LSB +: NUM_SAC];

  // event selection: single resource or boolean pair
  wire tsEvent = tsType ? resPair[tsSel] : resSingle[{1'b0, tsSel}];
  wire viewEvent = viType ? resPair[viSel[2:0]] : resSingle[viSel];

  // per-state exception level gating; unimplemented levels hold zero
  wire levelDisabled = instSecure ? sDisable[instLevel] : nsDisable[instLevel];

  // range test: no include selected means everything is included
  wire inclHit = |(rangeMatch & inclSel);
  wire inclOk = (inclSel == '0) | inclHit;
  wire exclHit = |(rangeMatch & exclSel);

  // start/stop comparator hits
  wire startHit = |(singleAddrMatch & startSel);
  wire stopHit = |(singleAddrMatch & stopSel);

  // ordinary instruction needs every filter term
  wire filterPass = viewEvent & started & inclOk & ~exclHit & ~levelDisabled;

  // exceptions follow the previous decision unless forced
  wire rstTrace = forceRst | prevTraced;
  wire errTrace = forceErr | prevTraced;
  wire decision = excReset ? rstTrace : (excSysError ? errTrace : filterPass);
  wire next_traceValid = instValid & decision;

  // main control readback shows live start/stop state
  wire [31:0] mainRead = (viMain & ITFC_WM_VI_MAIN) | (32'(started) << ITFC_VI_SS_BIT);

  // read selection; unmapped offsets read zero
  wire [31:0] rdMux =
    hitTs ? tsCtrl :
    hitId ? srcId :
    hitMain ? mainRead :
    hitRange ? viRange :
    hitSs ? viSs :
    hitGmLo ? gmValue :
    hitGmMask ? gmMask :
    32'h00000000; // upper compare word is reserved

  // stop wins when both hit in one cycle, so a stray start cannot reopen
  always_comb
  begin
    next_ssState = ssState;
    if (stopHit)
      next_ssState = ITFC_STOPPED;
    else if (startHit)
      next_ssState = ITFC_STARTED;
  end

  // control register writes, masked so reserved bits stay zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tsCtrl <= ITFC_RST_REG;
      srcId <= ITFC_RST_REG;
      viMain <= ITFC_RST_REG;
      viRange <= ITFC_RST_REG;
      viSs <= ITFC_RST_REG;
      gmMask <= ITFC_RST_REG;
    end
    else if (wrEn)
    begin
      if (hitTs)
        tsCtrl <= regWdata & ITFC_WM_TS_CTRL;
      if (hitId)
        srcId <= regWdata & ITFC_WM_SRC_ID;
      if (hitMain)
        viMain <= regWdata & ITFC_WM_VI_MAIN;
      if (hitRange)
        viRange <= regWdata & ITFC_WM_VI_RANGE;
      if (hitSs)
        viSs <= regWdata & ITFC_WM_VI_SS;
      if (hitGmMask)
        gmMask <= regWdata & ITFC_WM_GM_MASK;
    end
  end

  // low compare word; the high word ignores writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gmValue <= ITFC_RST_GM_VAL;
    else if (wrEn && hitGmLo)
      gmValue <= regWdata;
  end

  // register port answer, one cycle after the access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regRdata <= 32'h00000000;
      regAck <= 1'b0;
    end
    else
    begin
      regAck <= regSel;
      regRdata <= rdEn ? rdMux : 32'h00000000;
    end
  end

  // start/stop state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ssState <= ITFC_STOPPED;
    else
      ssState <= next_ssState;
  end

  // trace decision; prevTraced only moves on real instructions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      traceValid <= 1'b0;
      prevTraced <= 1'b0;
    end
    else
    begin
      traceValid <= next_traceValid;
      if (instValid)
        prevTraced <= next_traceValid;
    end
  end

  // one timestamp per firing, taken at the rising edge of the event
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tsEventD <= 1'b0;
      timestampReq <= 1'b0;
    end
    else
    begin
      tsEventD <= tsEvent;
      timestampReq <= tsEvent & ~tsEventD;
    end
  end

  // trace ID follows the source tag register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      traceIdOut <= '0;
    else
      traceIdOut <= srcId[ITFC_SRC_ID_W-1:0];
  end

  // guest machine tag comparator
  itfc_gm_if gmBus ();
  assign gmBus.cmpValue = gmValue;
  assign gmBus.ignoreMask = gmMask[3:0];
  assign gmBus.curTag = curGuestTag;
  assign guestTagMatch = gmBus.match; // flop inside the comparator

  itfc_guest_cmp u_guest_cmp
  (
    .clk(clk),
    .rst(rst),
    .gm(gmBus.cmp)
  );

  // checks
  chk_trace_id_write: assert property (@(posedge clk) disable iff (rst)
    (wrEn && hitId) |=> ##1 (traceIdOut == $past(regWdata[6:0], 2)))
    else $error("trace ID did not follow source tag write");

  chk_ts_single_edge: assert property (@(posedge clk) disable iff (rst)
    timestampReq |-> ($past(tsEvent) && !$past(tsEventD)))
    else $error("timestamp without a fresh event");

  chk_ts_pair_pick: assert property (@(posedge clk) disable iff (rst)
    (tsType && resPair[tsSel] && !tsEventD) |=> timestampReq)
    else $error("selected pair event gave no timestamp");

  chk_ns_level_off: assert property (@(posedge clk) disable iff (rst)
    (instValid && !instSecure && nsDisable[instLevel] && !excReset && !excSysError) |=> !traceValid)
    else $error("disabled non-secure level traced");

  chk_ns_el3_raz: assert property (@(posedge clk) disable iff (rst)
    (wrEn && hitMain) |=> (viMain[23] == 1'b0) && (viMain[18] == 1'b0))
    else $error("unimplemented level bit stored");

  chk_sec_level_off: assert property (@(posedge clk) disable iff (rst)
    (instValid && instSecure && sDisable[instLevel] && !excReset && !excSysError) |=> !traceValid)
    else $error("disabled secure level traced");

  chk_err_forced: assert property (@(posedge clk) disable iff (rst)
    (instValid && excSysError && !excReset && (forceErr || prevTraced)) |=> traceValid)
    else $error("system error not traced");

  chk_rst_follow: assert property (@(posedge clk) disable iff (rst)
    (instValid && excReset && !forceRst && !prevTraced) |=> !traceValid)
    else $error("unforced reset traced after untraced step");

  chk_ss_readback: assert property (@(posedge clk) disable iff (rst)
    (rdEn && hitMain) |=> (regRdata[9] == $past(started)))
    else $error("start/stop status readback wrong");

  chk_excl_block: assert property (@(posedge clk) disable iff (rst)
    (instValid && exclHit && !excReset && !excSysError) |=> !traceValid)
    else $error("excluded range traced");

  chk_empty_include: assert property (@(posedge clk) disable iff (rst)
    (instValid && !excReset && !excSysError && inclSel == '0 && viewEvent && started
     && !exclHit && !levelDisabled) |=> traceValid)
    else $error("empty include set blocked trace");

  chk_hi_word_zero: assert property (@(posedge clk) disable iff (rst)
    (rdEn && hitGmHi) |=> (regRdata == 32'h00000000))
    else $error("reserved compare word not zero");

  chk_start_stop: assert property (@(posedge clk) disable iff (rst)
    (startHit && !stopHit) |=> started)
    else $error("start/stop logic did not move");

  chk_stop_wins: assert property (@(posedge clk) disable iff (rst)
    stopHit |=> !started)
    else $error("stop match did not stop");

  chk_view_pick: assert property (@(posedge clk) disable iff (rst)
    (instValid && !excReset && !excSysError && !viewEvent) |=> !traceValid)
    else $error("traced without the view event");

  chk_reg_ack: assert property (@(posedge clk) disable iff (rst)
    regSel |=> regAck)
    else $error("register access not answered");

  chk_incl_block: assert property (@(posedge clk) disable iff (rst)
    (instValid && !excReset && !excSysError && inclSel != '0 && !inclHit) |=> !traceValid)
    else $error("instruction outside include ranges traced");

  chk_stopped_quiet: assert property (@(posedge clk) disable iff (rst)
    (instValid && !excReset && !excSysError && !started) |=> !traceValid)
    else $error("traced while stopped");

  chk_rst_forced: assert property (@(posedge clk) disable iff (rst)
    (instValid && excReset && forceRst) |=> traceValid)
    else $error("forced reset exception not traced");

  chk_err_follow: assert property (@(posedge clk) disable iff (rst)
    (instValid && excSysError && !excReset && !forceErr && !prevTraced) |=> !traceValid)
    else $error("unforced system error traced after untraced step");

  chk_ts_quiet: assert property (@(posedge clk) disable iff (rst)
    !tsEvent |=> !timestampReq)
    else $error("timestamp without the selected event");

endmodule : itfc_filter_ctrl

// >>> testbench/itfc_dbg_model.sv
// Purpose: debugger side of the register port, issues reads and writes
// Assumes: an access is taken on the rising edge that sees regSel high
// Notes: one access every other cycle; expected read data is queued for the bench monitor
`timescale 1ns/1ps
module itfc_dbg_model
(
  input wire logic clk,
  output logic regSel,
  output logic regWrite,
  output logic [11:0] regAddr,
  output logic [31:0] regWdata
);
  logic [31:0] expQ[$];
  logic kindQ[$];

  // idle port at time zero
  initial
  begin
    regSel = 1'b0;
    regWrite = 1'b0;
    regAddr = 12'hfff;
    regWdata = 32'h0;
  end

  // request held over the taking edge; released address and data show inverted junk, never the old value, while regWrite keeps its value
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [31:0] exp);
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= wr;
    regAddr <= addr;
    regWdata <= data;
    kindQ.push_back(!wr);
    if (!wr)
      expQ.push_back(exp);
    @(posedge clk);
    regSel <= 1'b0;
    regAddr <= ~addr;
    regWdata <= ~data;
  endtask : access
endmodule : itfc_dbg_model

// >>> testbench/itfc_filter_ctrl_tb.sv
// Purpose: self-checking bench for the instruction trace filter control block
// Assumes: debugger model drives the register port, bench drives the trace side
// Notes: expected results are queued by the drivers and popped by a monitor
`timescale 1ns/1ps
module itfc_filter_ctrl_tb;
  import itfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regSel, regWrite, regAck, instValid = 1'b0, instSecure = 1'b0, excReset = 1'b0, excSysError = 1'b0;
  logic traceValid, timestampReq, guestTagMatch, instSeen = 1'b0;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, curGuestTag = 32'h0;
  logic [15:0] resSingle = 16'h0, rs;
  logic [7:0] resPair = 8'h0, singleAddrMatch = 8'h0, rp;
  logic [3:0] rangeMatch = 4'h0, rm, gm, fl;
  logic [1:0] instLevel = 2'h0, lv;
  logic [6:0] traceIdOut;
  logic [31:0] vm, vr, x, idv, gv;
  logic [2:0] sel;
  logic sec, er, ee, iv, ev, dis, nrm, d, prev = 1'b0;
  logic trQ[$];
  int nErrors = 0, nTests = 0, cyc = 0;
  logic [11:0] offs [9] = '{ITFC_OFF_TS_CTRL, ITFC_OFF_SRC_ID, ITFC_OFF_VI_MAIN, ITFC_OFF_VI_RANGE, ITFC_OFF_VI_SS,
    ITFC_OFF_GM_VAL_LO, ITFC_OFF_GM_VAL_HI, ITFC_OFF_GM_MASK, 12'h100};
  logic [31:0] msks [9] = '{ITFC_WM_TS_CTRL, ITFC_WM_SRC_ID, ITFC_WM_VI_MAIN, ITFC_WM_VI_RANGE, ITFC_WM_VI_SS,
    32'hffffffff, 32'h0, ITFC_WM_GM_MASK, 32'h0};

  always #5 clk = ~clk;

  itfc_dbg_model itfc_dbg_model_i (.clk(clk), .regSel(regSel), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata));

  itfc_filter_ctrl itfc_filter_ctrl_i (.clk(clk), .rst(rst), .regSel(regSel), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck), .resSingle(resSingle),
    .resPair(resPair), .instValid(instValid), .instSecure(instSecure), .instLevel(instLevel),
    .excReset(excReset), .excSysError(excSysError), .rangeMatch(rangeMatch),
    .singleAddrMatch(singleAddrMatch), .curGuestTag(curGuestTag), .traceValid(traceValid),
    .traceIdOut(traceIdOut), .timestampReq(timestampReq), .guestTagMatch(guestTagMatch));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    itfc_dbg_model_i.access(1'b1, a, v, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    itfc_dbg_model_i.access(1'b0, a, 32'h0, e);
  endtask : rd

  // one start/stop comparator pulse, then read the state back
  task automatic ss(input logic [7:0] m, input logic e);
    @(posedge clk);
    singleAddrMatch <= m;
    @(posedge clk);
    singleAddrMatch <= 8'h0;
    rd(ITFC_OFF_VI_MAIN, vm | {22'h0, e, 9'h0});
  endtask : ss

  task automatic testDone;
    $display("tests=%0d errors=%0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : testDone

  // monitor: every ack and every traced decision is matched against the oldest note
  always @(posedge clk)
  begin
    if (regAck === 1'b1)
    begin
      if (itfc_dbg_model_i.kindQ.size() == 0)
        chk(32'h1, 32'h0);
      else if (itfc_dbg_model_i.kindQ.pop_front())
        chk(regRdata, itfc_dbg_model_i.expQ.pop_front());
      else
        chk(regRdata, 32'h0);
    end
    if (instSeen)
      chk({31'h0, traceValid}, {31'h0, trQ.pop_front()});
    instSeen <= instValid;
  end

  // hang guard, generous against a run of a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      nErrors++;
      testDone();
    end
  end

  initial
  begin
    void'($urandom(32'h7644285a));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values, masked write-back, read-only and unmapped places
    for (int i = 0; i < 9; i++)
    begin
      x = $urandom();
      rd(offs[i], 32'h0);
      wr(offs[i], x);
      rd(offs[i], x & msks[i]);
      if (i == 1)
        idv = x;
    end
    chk({25'h0, traceIdOut}, {25'h0, idv[6:0]});
    wr(ITFC_OFF_VI_SS, 32'h00400003);
    // phase 0 runs stopped, phase 1 started; random filter settings and instructions
    for (int ph = 0; ph < 2; ph++)
      for (int b = 0; b < 4; b++)
      begin
        vm = $urandom() & ITFC_WM_VI_MAIN;
        vr = $urandom() & ITFC_WM_VI_RANGE;
        wr(ITFC_OFF_VI_MAIN, vm);
        wr(ITFC_OFF_VI_RANGE, vr);
        if (ph == 1 && b == 0)
        begin
          ss(8'h02, 1'b1);
          ss(8'h40, 1'b0);
          ss(8'h42, 1'b0);
          ss(8'h04, 1'b0);
          ss(8'h01, 1'b1);
        end
        for (int k = 0; k < 16; k++)
        begin
          @(posedge clk);
          rs = $urandom();
          rp = $urandom();
          rm = $urandom();
          sec = $urandom();
          lv = $urandom();
          er = ($urandom() % 5 == 0);
          ee = ($urandom() % 5 == 0);
          iv = ($urandom() % 4 != 0);
          resSingle <= rs;
          resPair <= rp;
          rangeMatch <= rm;
          instSecure <= sec;
          instLevel <= lv;
          excReset <= er;
          excSysError <= ee;
          instValid <= iv;
          ev = vm[7] ? rp[vm[2:0]] : rs[vm[3:0]];
          dis = vm[(sec ? 16 : 20) + lv];
          nrm = ev & ph[0] & ((vr[3:0] == 4'h0) | (|(vr[3:0] & rm))) & ~(|(vr[19:16] & rm)) & ~dis;
          d = er ? (vm[10] | prev) : ee ? (vm[11] | prev) : nrm;
          if (iv)
          begin
            trQ.push_back(d);
            prev = d;
          end
        end
        @(posedge clk);
        instValid <= 1'b0;
        resSingle <= 16'h0;
        resPair <= 8'h0;
      end
    // timestamp on each rising edge of the chosen single or pair resource
    for (int t = 0; t < 4; t++)
    begin
      sel = $urandom();
      wr(ITFC_OFF_TS_CTRL, {24'h0, t[0], 3'h0, sel, 1'b0});
      @(posedge clk);
      if (t[0])
        resPair[sel] <= 1'b1;
      else
        resSingle[sel] <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      chk({31'h0, timestampReq}, 32'h1);
      @(posedge clk);
      chk({31'h0, timestampReq}, 32'h0);
      resSingle <= 16'h0;
      resPair <= 8'h0;
    end
    // guest tag compare with bytes flipped and masked
    for (int g = 0; g < 8; g++)
    begin
      gv = $urandom();
      gm = $urandom();
      fl = $urandom();
      wr(ITFC_OFF_GM_VAL_LO, gv);
      wr(ITFC_OFF_GM_MASK, {28'h0, gm});
      @(posedge clk);
      curGuestTag <= gv ^ {7'h0, fl[3], 7'h0, fl[2], 7'h0, fl[1], 7'h0, fl[0]};
      @(posedge clk);
      @(posedge clk);
      chk({31'h0, guestTagMatch}, {31'h0, (fl & ~gm) == 4'h0});
    end
    repeat (4) @(posedge clk);
    // every access answered and every traced item seen
    chk(itfc_dbg_model_i.kindQ.size(), 32'h0);
    chk(trQ.size(), 32'h0);
    testDone();
  end
endmodule : itfc_filter_ctrl_tb
